//--- common/roc_defines.svh
`ifndef ROC_DEFINES_SVH
`define ROC_DEFINES_SVH

// Register byte offsets
`define ROC_OFS_HOLD     8'h00
`define ROC_OFS_INV      8'h04
`define ROC_OFS_SRC      8'h08
`define ROC_OFS_MODE     8'h0C
`define ROC_OFS_NODE0    8'h10
`define ROC_OFS_NODE3    8'h1C
`define ROC_OFS_STAT     8'h20

// Reset values
`define ROC_HOLD_RST     16'h000A
`define ROC_INV_RST      4'h0
`define ROC_SRC_RST      16'h0000
`define ROC_NODE_RST     16'h0000

// Source select codes, four bits per output
`define ROC_SRC_OFF      4'h0
`define ROC_SRC_TOOL0    4'h1
`define ROC_SRC_TOOL7    4'h8
`define ROC_SRC_PRESENT  4'h9
`define ROC_SRC_PART_OK  4'hA
`define ROC_SRC_DEFECT   4'hB
`define ROC_SRC_NODE0    4'hC

// Node word: op in [1:0], tool mask in [11:4], node mask in [15:12]
`define ROC_NODE_TOOL_LSB 4
`define ROC_NODE_NODE_LSB 12

// Status fields
`define ROC_STAT_TRIG    4
`define ROC_STAT_BUSY    5
`define ROC_STAT_ERR_LSB 8

// Millisecond timebase
`define ROC_CLK_NS       40
`define ROC_TICK_NS      1000000
`define ROC_TICK_CYCLES  (`ROC_TICK_NS / `ROC_CLK_NS)

`endif

//--- common/roc_pkg.sv
`default_nettype none
package roc_pkg;

	typedef enum logic [1:0] {
		ROC_OP_AND = 2'h0,
		ROC_OP_OR  = 2'h1,
		ROC_OP_XOR = 2'h2,
		ROC_OP_NOT = 2'h3
	} roc_op_e;

	typedef enum logic [1:0] {
		ROC_T_IDLE = 2'b01,
		ROC_T_HOLD = 2'b10
	} roc_tstate_e;

	typedef logic [15:0] roc_node_t;

endpackage
`default_nettype wire

//--- common/roc_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface roc_tmr_if;
	logic        restart;
	logic [15:0] hold_ms;
	logic        busy;
	modport ctrl (output restart, output hold_ms, input busy);
	modport tmr  (input restart, input hold_ms, output busy);
endinterface
`default_nettype wire

//--- logic/roc_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "roc_defines.svh"
module roc_timer
	import roc_pkg::*;
#(
	parameter int TICK_CYCLES = `ROC_TICK_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Hold control
	roc_tmr_if.tmr   tm
);
	typedef struct packed {
		roc_tstate_e st;
		logic [15:0] pre;
		logic [15:0] ms;
	} roc_tmr_s;

	roc_tmr_s q;
	roc_tmr_s d;
	logic     tick;

	assign tick    = (q.pre == 16'(TICK_CYCLES - 1));
	assign tm.busy = (q.st == ROC_T_HOLD);

	always_comb begin
		d = q;
		d.pre = tick ? 16'h0000 : q.pre + 16'h0001;
		case (q.st)
			ROC_T_IDLE: begin
			end
			ROC_T_HOLD: begin
				if (tick) begin
					d.ms = q.ms - 16'h0001;
					if (q.ms == 16'h0001) begin
						d.st = ROC_T_IDLE;
					end
				end
			end
			default: begin
				d.st = ROC_T_IDLE;
			end
		endcase
		if (tm.restart) begin
			d.pre = 16'h0000;
			d.ms  = tm.hold_ms;
			d.st  = (tm.hold_ms == 16'h0000) ? ROC_T_IDLE : ROC_T_HOLD;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			q <= '{st: ROC_T_IDLE, pre: 16'h0000, ms: 16'h0000};
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	chk_restart_arms: assert property (tm.restart && tm.hold_ms != 16'h0000 |=> tm.busy && q.ms == $past(tm.hold_ms))
		else $error("timer not armed on restart");
	chk_zero_idle: assert property (tm.restart && tm.hold_ms == 16'h0000 |=> !tm.busy)
		else $error("zero hold armed the timer");
	chk_busy_until_last: assert property (tm.busy && q.ms > 16'h0001 && !tm.restart |=> tm.busy)
		else $error("hold ended early");
endmodule
`default_nettype wire

//--- logic/roc_top.sv
// What this block does
// - After a result is latched each output keeps its value for the hold time in milliseconds, 10 ms after reset.
// - A hold time of zero keeps the outputs at the latched result until the next result, as a signal extender.
// - An inverted output is low for a passing result and high for a failing one.
// - Without inversion, the reset setting, an output is high for a passing result and low otherwise.
// - One shared hold time governs every switching output at once.
// - Output 4 passes the trigger output while unassigned and becomes a general output once a source is set.
// - In logic mode an output may take its value from a logic node or a chain of nodes over tool results.
// - In logic mode the part present, part passing and part defective sources are unavailable.
// - An AND node passes only when all of its connected inputs pass.
// - An OR node passes when at least one connected input passes.
// - An XOR node takes at most two inputs and passes when they differ.
// - A NOT node takes at most one input and gives its opposite.
`timescale 1ns/1ps
`default_nettype none
`include "roc_defines.svh"
module roc_top
	import roc_pkg::*;
#(
	parameter int TICK_CYCLES = `ROC_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Inspection results
	input  wire logic        result_valid,
	input  wire logic [7:0]  tool_pass,
	input  wire logic        trig_in,
	// Switching outputs
	output logic      [3:0]  sw_out
);
	typedef struct packed {
		logic [15:0]          hold_ms;
		logic [3:0]           invert;
		logic [3:0][3:0]      src_sel;
		logic                 logic_mode;
		logic [3:0][15:0]     node_cfg;
		logic [3:0]           out_q;
		logic                 shown;
		logic [3:0]           pins;
		logic                 dp_sel;
		logic                 dp_write;
		logic [7:0]           dp_addr;
		logic [31:0]          rdata;
	} roc_top_s;

	roc_top_s   q;
	roc_top_s   d;
	roc_tmr_if  tm ();
	logic [3:0] node_val;
	logic [3:0] node_err;
	logic [3:0] src_act;
	logic [3:0] src_pass;
	logic       show;

	// Returns {error, pass} of one node over tool results and lower nodes
	function automatic logic [1:0] eval_node(input roc_node_t cfg, input logic [7:0] tools,
			input logic [3:0] lower);
		logic [11:0] m;
		logic [11:0] v;
		logic [3:0]  n;
		logic [1:0]  r;
		m = {cfg[`ROC_NODE_NODE_LSB +: 4], cfg[`ROC_NODE_TOOL_LSB +: 8]};
		v = {lower, tools};
		n = 4'h0;
		for (int i = 0; i < 12; i++) begin
			n = n + {3'h0, m[i]};
		end
		case (roc_op_e'(cfg[1:0]))
			ROC_OP_AND: r = {1'b0, ((v | ~m) == 12'hFFF) && (n != 4'h0)};
			ROC_OP_OR: r = {1'b0, |(v & m)};
			ROC_OP_XOR: r = (n > 4'h2) ? 2'h2 : {1'b0, ^(v & m)};
			ROC_OP_NOT: r = (n > 4'h1) ? 2'h2 : {1'b0, ~|(v & m)};
			default: r = 2'h0;
		endcase
		return r;
	endfunction

	// Returns {active, pass} of a source code
	function automatic logic [1:0] eval_src(input logic [3:0] code, input logic [7:0] tools,
			input logic [3:0] nodes, input logic lmode);
		logic [1:0] r;
		r = 2'h0;
		if (code >= `ROC_SRC_TOOL0 && code <= `ROC_SRC_TOOL7) begin
			r = {1'b1, tools[3'(code - `ROC_SRC_TOOL0)]};
		end else if (code >= `ROC_SRC_NODE0) begin
			// node sourcing only in logic mode
			r = {lmode, nodes[2'(code - `ROC_SRC_NODE0)]};
		end else if (!lmode) begin
			// collective sources off in logic mode
			case (code)
				`ROC_SRC_PRESENT: r = {1'b1, tools[0]};
				`ROC_SRC_PART_OK: r = {1'b1, &tools};
				`ROC_SRC_DEFECT:  r = {1'b1, ~&tools};
				default:          r = 2'h0;
			endcase
		end
		return r;
	endfunction

	// chain of nodes, each may read lower-numbered ones
	always_comb begin
		logic [3:0] lower;
		logic [1:0] res;
		lower    = 4'h0;
		res      = 2'h0;
		node_val = 4'h0;
		node_err = 4'h0;
		for (int i = 0; i < 4; i++) begin
			lower       = node_val & ((4'h1 << i) - 4'h1);
			res         = eval_node(q.node_cfg[i], tool_pass, lower);
			node_val[i] = res[0] & ~res[1];
			node_err[i] = res[1];
		end
	end

	always_comb begin
		logic [1:0] s;
		s        = 2'h0;
		src_act  = 4'h0;
		src_pass = 4'h0;
		for (int i = 0; i < 4; i++) begin
			s           = eval_src(q.src_sel[i], tool_pass, node_val, q.logic_mode);
			src_act[i]  = s[1];
			src_pass[i] = s[0];
		end
	end

	// every result restarts the shared timer
	assign tm.restart = result_valid;
	// one hold value for all outputs
	assign tm.hold_ms = q.hold_ms;

	roc_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.mclk (mclk),
		.nrst (nrst),
		.tm   (tm)
	);

	always_comb begin
		d = q;
		d.dp_sel = 1'b0;
		if (result_valid) begin
			d.out_q = (src_pass ^ q.invert) & src_act;
		end
		// AHB data phase write
		if (q.dp_sel && q.dp_write) begin
			case (q.dp_addr)
				`ROC_OFS_HOLD: d.hold_ms = hwdata[15:0];
				`ROC_OFS_INV:  d.invert = hwdata[3:0];
				`ROC_OFS_SRC:  d.src_sel = hwdata[15:0];
				`ROC_OFS_MODE: d.logic_mode = hwdata[0];
				default: begin
					if (q.dp_addr >= `ROC_OFS_NODE0 && q.dp_addr <= `ROC_OFS_NODE3) begin
						d.node_cfg[2'(q.dp_addr[7:2] - 6'h04)] = hwdata[15:0];
					end
				end
			endcase
		end
		// AHB address phase; read data taken from the updated copy
		if (hsel && hready && htrans[1]) begin
			d.dp_sel   = 1'b1;
			d.dp_write = hwrite;
			d.dp_addr  = {haddr[7:2], 2'h0};
			d.rdata    = 32'h0000_0000;
			case ({haddr[7:2], 2'h0})
				`ROC_OFS_HOLD: d.rdata[15:0] = d.hold_ms;
				`ROC_OFS_INV:  d.rdata[3:0] = d.invert;
				`ROC_OFS_SRC:  d.rdata[15:0] = d.src_sel;
				`ROC_OFS_MODE: d.rdata[0] = d.logic_mode;
				`ROC_OFS_STAT: begin
					d.rdata[3:0] = q.pins;
					d.rdata[`ROC_STAT_TRIG] = (q.src_sel[3] == `ROC_SRC_OFF);
					d.rdata[`ROC_STAT_BUSY] = tm.busy;
					d.rdata[`ROC_STAT_ERR_LSB +: 4] = node_err;
				end
				default: begin
					if (haddr[7:0] >= `ROC_OFS_NODE0 && haddr[7:0] <= `ROC_OFS_NODE3) begin
						d.rdata[15:0] = d.node_cfg[2'(haddr[7:2] - 6'h04)];
					end
				end
			endcase
		end
		// zero hold extends until next result
		show   = result_valid || tm.busy || (q.hold_ms == 16'h0000 && q.shown);
		d.pins = show ? d.out_q : 4'h0;
		// Expired result is not revived by a later switch to zero hold
		d.shown = show;
		// output 4 falls back to trigger
		if (q.src_sel[3] == `ROC_SRC_OFF) begin
			d.pins[3] = trig_in;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			q <= '0;
			q.hold_ms <= `ROC_HOLD_RST;
			q.invert <= `ROC_INV_RST;
			q.src_sel <= `ROC_SRC_RST;
		end else begin
			q <= d;
		end
	end

	assign hrdata    = q.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign sw_out    = q.pins;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence seq_result_out0;
		result_valid && src_act[0];
	endsequence

	sequence seq_idle_extend;
		q.hold_ms == 16'h0000 && q.shown && !result_valid;
	endsequence

	chk_hold_reset: assert property (disable iff (1'b0) !nrst |=> q.hold_ms == `ROC_HOLD_RST)
		else $error("hold time reset value wrong");
	chk_out_polarity: assert property (seq_result_out0 ##1 1'b1 |-> q.out_q[0] == ($past(src_pass[0]) ^ $past(q.invert[0])))
		else $error("output polarity wrong");
	chk_plain_high: assert property (seq_result_out0 ##0 (!q.invert[0] && src_pass[0]) |=> ##1 sw_out[0] || result_valid)
		else $error("passing plain output not high");
	chk_extend_stable: assert property (seq_idle_extend ##1 seq_idle_extend |-> $stable(sw_out[2:0]))
		else $error("extender output changed");
	chk_shared_blank: assert property (q.hold_ms != 16'h0000 && !tm.busy && !result_valid |=> sw_out[2:0] == 3'h0)
		else $error("outputs not cleared together");
	chk_trig_pass: assert property (q.src_sel[3] == `ROC_SRC_OFF |=> sw_out[3] == $past(trig_in))
		else $error("trigger not passed to output 4");
	chk_no_collect: assert property (q.logic_mode && q.src_sel[0] >= `ROC_SRC_PRESENT && q.src_sel[0] <= `ROC_SRC_DEFECT
			|-> !src_act[0])
		else $error("collective source used in logic mode");
	chk_and_node: assert property (q.node_cfg[0][1:0] == ROC_OP_AND && q.node_cfg[0][11:4] != 8'h00
			|-> node_val[0] == ((tool_pass & q.node_cfg[0][11:4]) == q.node_cfg[0][11:4]))
		else $error("AND node wrong");
	chk_or_node: assert property (q.node_cfg[0][1:0] == ROC_OP_OR |-> node_val[0] == |(tool_pass & q.node_cfg[0][11:4]))
		else $error("OR node wrong");
	chk_xor_node: assert property (q.node_cfg[0][1:0] == ROC_OP_XOR && q.node_cfg[0][11:4] == 8'h03
			|-> node_val[0] == (tool_pass[0] != tool_pass[1]))
		else $error("XOR node wrong");
	chk_not_node: assert property (q.node_cfg[0][1:0] == ROC_OP_NOT && q.node_cfg[0][11:4] == 8'h01
			|-> node_val[0] == !tool_pass[0])
		else $error("NOT node wrong");
endmodule
`default_nettype wire

//--- testbench/roc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module roc_ctrl_model #(
	parameter int GAP = 60
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Sensor side
	input  wire logic [3:0] sw_out,
	output logic            result_valid,
	output logic      [7:0] tool_pass
);
	int idle_cnt;

	initial begin
		result_valid = 1'h0;
		tool_pass    = 8'h00;
	end

	always @(posedge mclk) begin
		if (!nrst)
			idle_cnt <= GAP;
		else if (result_valid)
			idle_cnt <= 0;
		else if (idle_cnt < GAP)
			idle_cnt <= idle_cnt + 1;
	end

	task automatic send(input logic [7:0] pat, input bit rush, output logic [3:0] seen);
		// wait out the hold unless hurried
		while (!rush && idle_cnt < GAP)
			@(posedge mclk);
		result_valid <= 1'h1;
		tool_pass    <= pat;
		@(posedge mclk);
		result_valid <= 1'h0;
		// Stale lines show the opposite pattern
		tool_pass    <= ~pat;
		@(posedge mclk);
		seen = sw_out;
	endtask
endmodule
`default_nettype wire

//--- testbench/roc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "roc_defines.svh"
module roc_top_bench;
	localparam int TICK = 4;
	typedef struct packed {
		logic             mode;
		logic [15:0]      src;
		logic [3:0]       inv;
		logic [3:0][15:0] nodes;
		logic [7:0]       tools;
		logic [3:0]       exp;
	} roc_row_s;

	logic        mclk;
	logic        nrst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        result_valid;
	logic [7:0]  tool_pass;
	logic        trig_in;
	logic [3:0]  sw_out;
	logic [31:0] q;
	logic [3:0]  s;
	int          n;
	int          fail_count;
	int          cmp_count;
	roc_row_s    rows [15] = '{
		'{1'h0, 16'hBA81, 4'h0, 64'h0, 8'h01, 4'h9},
		'{1'h0, 16'h9009, 4'h0, 64'h0, 8'h01, 4'h9},
		'{1'h1, 16'h9009, 4'h0, 64'h0, 8'h01, 4'h0},
		'{1'h1, 16'h000C, 4'h0, 64'h0031, 8'h02, 4'h1},
		'{1'h1, 16'h000C, 4'h0, 64'h0032, 8'h02, 4'h1},
		'{1'h1, 16'h000C, 4'h0, 64'h0013, 8'h00, 4'h1},
		'{1'h0, 16'hBA81, 4'hF, 64'h0, 8'h01, 4'h6},
		'{1'h0, 16'hBA81, 4'h0, 64'h0, 8'hFF, 4'h7},
		'{1'h1, 16'hBA81, 4'h0, 64'h0, 8'hFF, 4'h3},
		'{1'h1, 16'hFEDC, 4'h0, 64'h1003_0032_0031_0030, 8'h01, 4'hE},
		'{1'h1, 16'hFEDC, 4'h0, 64'h1003_0032_0031_0030, 8'h03, 4'h3},
		'{1'h1, 16'hFEDC, 4'h0, 64'h1003_0032_0031_0030, 8'h00, 4'h8},
		'{1'h1, 16'hFEDC, 4'hF, 64'h1003_0032_0031_0030, 8'h03, 4'hC},
		'{1'h1, 16'h000C, 4'h0, 64'h0072, 8'h01, 4'h0},
		'{1'h1, 16'h000C, 4'h0, 64'h0033, 8'h00, 4'h0}
	};

	assign hready = hreadyout;

	roc_top #(.TICK_CYCLES(TICK)) i_dut (
		.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.result_valid(result_valid), .tool_pass(tool_pass), .trig_in(trig_in), .sw_out(sw_out)
	);

	roc_ctrl_model #(.GAP(60)) i_ctrl (
		.mclk(mclk), .nrst(nrst), .sw_out(sw_out), .result_valid(result_valid), .tool_pass(tool_pass)
	);

	initial begin
		mclk = 1'h0;
		forever #20 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		hsel   <= 1'h1;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge mclk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'h1);
		r = hrdata;
	endtask

	task automatic hold_len(input logic [3:0] e, output int cnt);
		cnt = 0;
		while (sw_out === e && cnt < 500) begin
			cnt++;
			@(posedge mclk);
		end
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		give_verdict();
	end

	initial begin
		nrst    = 1'h0;
		hsel    = 1'h0;
		haddr   = 32'h0;
		htrans  = 2'h0;
		hwrite  = 1'h0;
		hsize   = 3'h2;
		hwdata  = 32'h0;
		trig_in = 1'h0;
		repeat (3) @(posedge mclk);
		nrst <= 1'h1;
		for (int i = 0; i < 7; i++) begin
			bus(1'h0, (i == 6) ? 8'h40 : 8'(4 * i), 32'h0, q);
			check(q, (i == 0) ? 32'h0000_000A : 32'h0); // reset values
		end
		check({31'h0, hresp}, 32'h0);
		trig_in <= 1'h1;
		repeat (2) @(posedge mclk);
		check({28'h0, sw_out}, 32'h8); // trigger pass-through
		trig_in <= 1'h0;
		$display("test reset done");
		foreach (rows[i]) begin
			bus(1'h1, `ROC_OFS_MODE, {31'h0, rows[i].mode}, q);
			bus(1'h1, `ROC_OFS_SRC, {16'h0, rows[i].src}, q);
			bus(1'h1, `ROC_OFS_INV, {28'h0, rows[i].inv}, q);
			for (int k = 0; k < 4; k++)
				bus(1'h1, `ROC_OFS_NODE0 + 8'(4 * k), {16'h0, rows[i].nodes[k]}, q);
			i_ctrl.send(rows[i].tools, 1'b0, s);
			check({28'h0, s}, {28'h0, rows[i].exp}); // Output levels
		end
		$display("test table done");
		bus(1'h1, `ROC_OFS_MODE, 32'h0, q);
		bus(1'h1, `ROC_OFS_INV, 32'h0, q);
		bus(1'h1, `ROC_OFS_SRC, 32'h1, q);
		i_ctrl.send(8'h01, 1'b0, s);
		repeat (20) @(posedge mclk);
		i_ctrl.send(8'h03, 1'b1, s);
		hold_len(4'h1, n);
		check(n, 10 * TICK + 1); // Restarted hold
		check({28'h0, sw_out}, 32'h0); // Off after hold
		$display("test restart done");
		bus(1'h1, `ROC_OFS_HOLD, 32'h3, q);
		bus(1'h1, `ROC_OFS_SRC, 32'h1111, q);
		i_ctrl.send(8'h01, 1'b0, s);
		hold_len(4'hF, n);
		check(n, 3 * TICK + 1); // Shared hold
		$display("test shared hold done");
		bus(1'h1, `ROC_OFS_HOLD, 32'h0, q);
		bus(1'h1, `ROC_OFS_SRC, 32'h1, q);
		i_ctrl.send(8'h01, 1'b0, s);
		repeat (100) @(posedge mclk);
		check({28'h0, sw_out}, 32'h1); // Extender keeps level
		bus(1'h0, `ROC_OFS_STAT, 32'h0, q);
		check(q, 32'h0000_0111); // Status mirror
		i_ctrl.send(8'h00, 1'b0, s);
		check({28'h0, s}, 32'h0); // Extender follows result
		$display("test extender done");
		nrst <= 1'h0;
		@(posedge mclk);
		nrst <= 1'h1;
		bus(1'h0, `ROC_OFS_HOLD, 32'h0, q);
		check(q, 32'h0000_000A); // Hold default again
		$display("test second reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
